/* File: verilog/dmc_mode_config.v */
`timescale 1ns/1ps
`default_nettype none
`include "dmc_regs.vh"
module dmc_mode_config (
   // Clock and reset.
   input wire clk,
   input wire rstn,
   // Device organisation strap, sampled continuously.
   input wire [1:0] org,
   // Command bus, one command per asserted select.
   input wire cs_n,
   input wire act_n,
   input wire ras_n,
   input wire cas_n,
   input wire we_n,
   input wire [21:0] addr,
   input wire par,
   // Maximum power saving exit request.
   input wire mps_exit,
   // CRC error event and multipurpose-register read flag from datapath.
   input wire crc_err_evt,
   input wire mpr_read,
   // Decoded command outputs.
   output reg cmd_valid,
   output reg [21:0] cmd_addr,
   output reg [2:0] cmd_code,
   // Register contents.
   output reg [21:0] data_bus_parity_termination_config,
   output reg [21:0] power_refresh_preamble_config,
   // Feature controls.
   output reg rd_inv_active,
   output reg wr_inv_active,
   output reg wr_mask_active,
   output reg [2:0] parked_termination,
   output reg odt_buf_off_pd,
   output reg [3:0] parity_latency,
   output reg [3:0] cal_clocks,
   output reg tcr_enable,
   output reg tcr_extended,
   output reg mps_active,
   output reg preamble_training,
   output reg preamble_two_clk
);
   localparam ST_IDLE = 3'b001;
   localparam ST_WAIT = 3'b010;
   localparam ST_MPS = 3'b100;
   // Maps latency field codes to clocks; reserved codes read as zero (disabled).
   function [3:0] cal_decode;
      input [2:0] code;
      begin
         case (code)
            3'h1: cal_decode = 4'h3;
            3'h2: cal_decode = 4'h4;
            3'h3: cal_decode = 4'h5;
            3'h4: cal_decode = 4'h6;
            3'h5: cal_decode = 4'h8;
            default: cal_decode = 4'h0;
         endcase
      end
   endfunction
   function [3:0] plat_decode;
      input [2:0] code;
      begin
         case (code)
            3'h1: plat_decode = 4'h4;
            3'h2: plat_decode = 4'h5;
            3'h3: plat_decode = 4'h6;
            default: plat_decode = 4'h0;
         endcase
      end
   endfunction
   reg [2:0] state;
   reg [3:0] wait_cnt;
   reg [21:0] held_addr;
   reg [2:0] held_code;
   reg held_par;
   wire [3:0] cal_cfg = cal_decode(power_refresh_preamble_config[`DMC_CAL_HI:`DMC_CAL_LO]);
   wire [3:0] plat_cfg = plat_decode(data_bus_parity_termination_config[`DMC_PLAT_HI:`DMC_PLAT_LO]);
   wire wide_org = (org == `DMC_ORG_X8) || (org == `DMC_ORG_X16);
   wire sel_low = ~cs_n;
   // Captured command: immediate when latency is off, else delayed copy.
   wire cap_now = (state == ST_WAIT) && (wait_cnt == 4'h1);
   wire take = (state == ST_IDLE) && sel_low && (cal_cfg == 4'h0);
   wire cmd_go = take || cap_now;
   wire [21:0] c_addr = cap_now ? held_addr : addr;
   wire [2:0] c_code = cap_now ? held_code : {ras_n, cas_n, we_n};
   wire c_act = cap_now ? 1'b0 : ~act_n;
   wire c_par = cap_now ? held_par : par;
   // Mode set is a non-activate command with all three strobes low.
   wire is_mrs = cmd_go && !c_act && (c_code == 3'h0);
   wire sel_dnu = c_addr[`DMC_SEL_HI:`DMC_SEL_LO] == `DMC_SEL_DNU;
   wire wr_dbpt = is_mrs && (c_addr[`DMC_SEL_HI:`DMC_SEL_LO] == `DMC_SEL_DBPT);
   wire wr_prpc = is_mrs && (c_addr[`DMC_SEL_HI:`DMC_SEL_LO] == `DMC_SEL_PRPC);
   // Parity covers the activate pin as driven, so the low-active level enters the sum.
   wire par_bad = (^{~c_act, c_code, c_addr}) != c_par;
   wire par_on = plat_cfg != 4'h0;
   // Persistent mode keeps checking with the status bit set.
   wire par_check = par_on && (data_bus_parity_termination_config[`DMC_PERSIST] ||
                               !data_bus_parity_termination_config[`DMC_PAR_ERR]);
   wire par_evt = cmd_go && par_check && par_bad;
   reg [21:0] next_dbpt;
   always @* begin
      next_dbpt = data_bus_parity_termination_config;
      if (wr_dbpt && !par_evt) begin
         // Reserved positions are held at zero regardless of what is written.
         next_dbpt = c_addr;
         next_dbpt[`DMC_SEL_HI:`DMC_SEL_LO] = 3'h0;
         next_dbpt[`DMC_RSV_A] = 1'b0;
         next_dbpt[`DMC_RSV_B] = 1'b0;
         next_dbpt[`DMC_RSV_C] = 1'b0;
      end
      // Setting beats a same-cycle clear.
      if (par_evt)
         next_dbpt[`DMC_PAR_ERR] = 1'b1;
      if (crc_err_evt)
         next_dbpt[`DMC_CRC_ERR] = 1'b1;
   end
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state <= ST_IDLE;
         wait_cnt <= 4'h0;
         held_addr <= 22'h000000;
         held_code <= 3'h7;
         held_par <= 1'b0;
         data_bus_parity_termination_config <= `DMC_DBPT_RESET;
         power_refresh_preamble_config <= `DMC_PRPC_RESET;
         cmd_valid <= 1'b0;
         cmd_addr <= 22'h000000;
         cmd_code <= 3'h7;
      end else begin
         data_bus_parity_termination_config <= next_dbpt;
         // A command that fails parity is not executed.
         cmd_valid <= cmd_go && !par_evt && !(is_mrs && sel_dnu);
         cmd_addr <= c_addr;
         cmd_code <= c_code;
         if (wr_prpc && !par_evt) begin
            power_refresh_preamble_config <= c_addr & 22'h003fff;
            power_refresh_preamble_config[0] <= 1'b0;
         end
         case (state)
            ST_IDLE: begin
               if (sel_low && cal_cfg != 4'h0) begin
                  state <= ST_WAIT;
                  wait_cnt <= cal_cfg;
               end
               if (wr_prpc && !par_evt && c_addr[`DMC_MPS])
                  state <= ST_MPS;
            end
            ST_WAIT: begin
               wait_cnt <= wait_cnt - 4'h1;
               if (wait_cnt == 4'h2) begin
                  held_addr <= addr;
                  held_code <= {ras_n, cas_n, we_n};
                  held_par <= par;
               end
               if (cap_now) begin
                  state <= ST_IDLE;
                  if (wr_prpc && !par_evt && c_addr[`DMC_MPS])
                     state <= ST_MPS;
               end
            end
            ST_MPS: begin
               // Only the exit request leaves this state; commands are dropped.
               if (mps_exit) begin
                  state <= ST_IDLE;
                  power_refresh_preamble_config[`DMC_MPS] <= 1'b0;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_inv_active <= 1'b0;
         wr_inv_active <= 1'b0;
         wr_mask_active <= 1'b0;
         parked_termination <= 3'h0;
         odt_buf_off_pd <= 1'b0;
         parity_latency <= 4'h0;
         cal_clocks <= 4'h0;
         tcr_enable <= 1'b0;
         tcr_extended <= 1'b0;
         mps_active <= 1'b0;
         preamble_training <= 1'b0;
         preamble_two_clk <= 1'b0;
      end else begin
         // Read inversion is suppressed for multipurpose-register reads.
         rd_inv_active <= wide_org && data_bus_parity_termination_config[`DMC_RD_INV] && !mpr_read;
         wr_inv_active <= wide_org && data_bus_parity_termination_config[`DMC_WR_INV];
         // The mask only qualifies write data; the read path never sees it.
         wr_mask_active <= wide_org && data_bus_parity_termination_config[`DMC_MASK];
         parked_termination <= data_bus_parity_termination_config[`DMC_PARK_HI:`DMC_PARK_LO];
         odt_buf_off_pd <= data_bus_parity_termination_config[`DMC_ODT_BUF_OFF];
         parity_latency <= plat_cfg;
         cal_clocks <= cal_cfg;
         tcr_enable <= power_refresh_preamble_config[`DMC_TCR_EN];
         tcr_extended <= power_refresh_preamble_config[`DMC_TCR_EXT];
         mps_active <= state == ST_MPS;
         preamble_training <= power_refresh_preamble_config[`DMC_PRE_TRAIN];
         preamble_two_clk <= power_refresh_preamble_config[`DMC_RD_PRE];
      end
   end
endmodule // dmc_mode_config
`default_nettype wire

/* File: verilog/dmc_regs.vh */
`ifndef DMC_REGS_VH
`define DMC_REGS_VH
// Mode register select codes on bank group / bank address (bits 20:18).
`define DMC_SEL_HI 20
`define DMC_SEL_LO 18
`define DMC_SEL_PRPC 3'h4
`define DMC_SEL_DBPT 3'h5
`define DMC_SEL_DNU 3'h7
// Data-bus, parity and termination configuration fields.
`define DMC_RSV_A 21
`define DMC_RSV_B 17
`define DMC_RSV_C 13
`define DMC_RD_INV 12
`define DMC_WR_INV 11
`define DMC_MASK 10
`define DMC_PERSIST 9
`define DMC_PARK_HI 8
`define DMC_PARK_LO 6
`define DMC_ODT_BUF_OFF 5
`define DMC_PAR_ERR 4
`define DMC_CRC_ERR 3
`define DMC_PLAT_HI 2
`define DMC_PLAT_LO 0
`define DMC_DBPT_RESET 22'h000000
// Power, refresh and preamble configuration fields.
`define DMC_CAL_HI 8
`define DMC_CAL_LO 6
`define DMC_RD_PRE 11
`define DMC_PRE_TRAIN 10
`define DMC_TCR_EN 3
`define DMC_TCR_EXT 2
`define DMC_MPS 1
`define DMC_PRPC_RESET 22'h000000
// Device organisation codes.
`define DMC_ORG_X4 2'h0
`define DMC_ORG_X8 2'h1
`define DMC_ORG_X16 2'h2
`endif

/* File: sim/dmc_mode_config_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module dmc_chk (
   // Clock, reset and command side.
   input wire logic clk, rstn, cs_n, act_n, ras_n, cas_n, we_n, par, mps_exit, crc_err_evt, mpr_read,
   input wire logic [1:0] org,
   input wire logic [21:0] addr,
   // Design outputs.
   input wire logic cmd_valid, rd_inv_active, wr_mask_active, mps_active,
   input wire logic [2:0] cmd_code,
   input wire logic [3:0] cal_clocks,
   input wire logic [21:0] data_bus_parity_termination_config, power_refresh_preamble_config
);
   wire [21:0] c = data_bus_parity_termination_config;
   wire [21:0] p = power_refresh_preamble_config;
   wire mrs = !cs_n && act_n && !ras_n && !cas_n && !we_n;
   wire mrs5 = mrs && addr[20:18] == 3'h5;
   wire bad = (^{act_n, ras_n, cas_n, we_n, addr}) != par;
   // A latched error stops checking unless persistent mode is on.
   wire chk = c[2:0] != 3'h0 && !(c[4] && !c[9]);
   wire live = !cs_n && p[8:6] == 3'h0 && cal_clocks == 4'h0 && !p[1] && !mps_active;
   wire ok = live && !(chk && bad);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   a_mrs_write: assert property (ok && mrs5 |=> c[12:5] == $past(addr[12:5]) && c[2:0] == $past(addr[2:0]))
      else $error("config write mismatch");
   a_cmd_report: assert property (ok && mrs && addr[20:18] != 3'h7 |=> cmd_valid && cmd_code == 3'h0)
      else $error("mode set not reported");
   a_dnu_silent: assert property (ok && mrs && addr[20:18] == 3'h7 |=> !cmd_valid)
      else $error("reserved select reported");
   a_parity_abort: assert property (live && chk && bad |=> !cmd_valid && c[4])
      else $error("parity error not handled");
   a_par_sticky: assert property ($fell(c[4]) |-> $past(mrs5))
      else $error("parity status dropped");
   a_crc_sticky: assert property (crc_err_evt && !p[1] |=> c[3])
      else $error("crc status not set");
   a_mpr_plain: assert property (mpr_read [*3] |-> !rd_inv_active)
      else $error("inversion during readout");
   a_x4_off: assert property ((org == 2'h0) [*3] |-> !rd_inv_active && !wr_mask_active)
      else $error("x4 feature active");
   a_dbi_follow: assert property ((org != 2'h0 && !mpr_read && c[12] && c[10]) [*3] |-> rd_inv_active && wr_mask_active)
      else $error("feature not enabled");
   a_mps_ignore: assert property (mps_active && p[1] && !mps_exit |=> !cmd_valid)
      else $error("command in power saving");
   c_par_err: cover property (live && chk && bad);
   c_mps: cover property ($rose(mps_active));
   c_crc: cover property (crc_err_evt);
endmodule // dmc_chk
bind dmc_mode_config dmc_chk i_chk (.clk(clk), .rstn(rstn), .cs_n(cs_n), .act_n(act_n), .ras_n(ras_n),
   .cas_n(cas_n), .we_n(we_n), .par(par), .mps_exit(mps_exit), .crc_err_evt(crc_err_evt), .mpr_read(mpr_read),
   .org(org), .addr(addr), .cmd_valid(cmd_valid), .rd_inv_active(rd_inv_active), .wr_mask_active(wr_mask_active),
   .mps_active(mps_active), .cmd_code(cmd_code), .cal_clocks(cal_clocks),
   .data_bus_parity_termination_config(data_bus_parity_termination_config),
   .power_refresh_preamble_config(power_refresh_preamble_config));
`default_nettype wire

/* File: sim/dmc_ctl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dmc_ctl_model (
   input wire logic clk,
   // Command bus towards the device.
   output logic cs_n, act_n, ras_n, cas_n, we_n, par,
   output logic [21:0] addr
);
   initial {cs_n, act_n, ras_n, cas_n, we_n, par, addr} = 28'hfc00000;
   // One mode set; flip spoils the parity on purpose.
   task automatic mrs(input logic [21:0] a, input logic flip);
      @(posedge clk);
      #1;
      {cs_n, act_n, ras_n, cas_n, we_n} = 5'h08;
      addr = a & 22'h1ddfff;
      par = (^{act_n, ras_n, cas_n, we_n, addr}) ^ flip;
      @(posedge clk);
      #1;
      {cs_n, act_n, ras_n, cas_n, we_n} = 5'h1f;
      // A released bus must not keep looking like the last command.
      addr = ~addr;
      par = ~par;
   endtask
endmodule // dmc_ctl_model
`default_nettype wire

/* File: sim/dmc_mode_config_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module dmc_mode_config_tb;
   localparam logic [21:0] S4 = 22'h100000, S5 = 22'h140000, S7 = 22'h1c0000;
   logic clk = 1'b0, rstn = 1'b0, mps_exit = 1'b0, crc_err_evt = 1'b0, mpr_read = 1'b0;
   logic [1:0] org = 2'h1;
   logic cs_n, act_n, ras_n, cas_n, we_n, par, rd_inv, wr_inv, wr_mask, odt_off, mps;
   logic [21:0] addr, cfg;
   logic [2:0] park;
   logic [3:0] plat;
   logic [3:0] cal;
   logic tcr_en, tcr_ext, pre_trn, pre_two;
   int n_mismatch = 0, num_checks = 0, cyc = 0;
   initial forever #2.5 clk = ~clk;
   dmc_ctl_model i_ctl (.clk(clk), .cs_n(cs_n), .act_n(act_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
      .par(par), .addr(addr));
   dmc_mode_config i_dut (.clk(clk), .rstn(rstn), .org(org), .cs_n(cs_n), .act_n(act_n), .ras_n(ras_n),
      .cas_n(cas_n), .we_n(we_n), .addr(addr), .par(par), .mps_exit(mps_exit), .crc_err_evt(crc_err_evt),
      .mpr_read(mpr_read), .cmd_valid(), .cmd_addr(), .cmd_code(), .data_bus_parity_termination_config(cfg),
      .power_refresh_preamble_config(), .rd_inv_active(rd_inv), .wr_inv_active(wr_inv), .wr_mask_active(wr_mask),
      .parked_termination(park), .odt_buf_off_pd(odt_off), .parity_latency(plat), .cal_clocks(cal),
      .tcr_enable(tcr_en), .tcr_extended(tcr_ext), .mps_active(mps), .preamble_training(pre_trn),
      .preamble_two_clk(pre_two));
   task automatic chk(input string nm, input logic [21:0] exp, input logic [21:0] got);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [21:0] a, input logic flip = 1'b0);
      i_ctl.mrs(a, flip);
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic pulse_wait(ref logic s);
      s = 1'b1;
      @(posedge clk);
      #1;
      s = 1'b0;
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic t_fields;
      for (int i = 0; i < 8; i++) begin
         // Gear-down is never enabled, so the five-clock code is legal here.
         wr(S5 | 22'(i << 6) | 22'(i < 4 ? i : 0) | 22'h20);
         chk("cfg", 22'(i << 6) | 22'(i < 4 ? i : 0) | 22'h20, cfg);
         chk("park", 22'(i), {19'h0, park});
         chk("plat", 22'(i > 0 && i < 4 ? i + 3 : 0), {18'h0, plat});
         chk("odt", 22'h1, {21'h0, odt_off});
      end
      $display("t_fields done");
   endtask
   task automatic t_dbi;
      wr(S5 | 22'h1400);
      chk("rd_inv", 22'h1, {21'h0, rd_inv});
      chk("mask", 22'h1, {21'h0, wr_mask});
      pulse_wait(mpr_read);
      mpr_read = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk("rd_inv", 22'h0, {21'h0, rd_inv});
      chk("mask", 22'h1, {21'h0, wr_mask});
      mpr_read = 1'b0;
      org = 2'h0;
      wr(S5 | 22'h1400);
      chk("x4", 22'h0, {20'h0, rd_inv, wr_mask});
      org = 2'h2;
      wr(S5 | 22'h800);
      chk("dbi", 22'h2, {19'h0, rd_inv, wr_inv, wr_mask});
      $display("t_dbi done");
   endtask
   task automatic t_parity;
      wr(S5 | 22'h1);
      wr(S5 | 22'h1000, 1'b1);
      chk("cfg", 22'h11, cfg);
      wr(S5 | 22'h1011, 1'b1);
      chk("cfg", 22'h1011, cfg);
      wr(S5 | 22'h201);
      chk("cfg", 22'h201, cfg);
      wr(S5 | 22'h201, 1'b1);
      wr(S5 | 22'h1211, 1'b1);
      chk("cfg", 22'h211, cfg);
      wr(S5);
      pulse_wait(crc_err_evt);
      chk("crc", 22'h8, cfg);
      wr(S5);
      chk("crc", 22'h0, cfg);
      $display("t_parity done");
   endtask
   task automatic t_mps;
      wr(S4 | 22'h2);
      chk("mps", 22'h1, {21'h0, mps});
      wr(S5 | 22'h1000);
      chk("cfg", 22'h0, cfg);
      pulse_wait(mps_exit);
      chk("mps", 22'h0, {21'h0, mps});
      wr(S7 | 22'h1000);
      chk("cfg", 22'h0, cfg);
      wr(S5 | 22'h1000);
      chk("cfg", 22'h1000, cfg);
      // Latency is left on afterwards, so this write must be the last command of the run.
      wr(S4 | 22'hc4c);
      chk("prpc", 22'h3f, {14'h0, cal, tcr_en, tcr_ext, pre_trn, pre_two});
      $display("t_mps done");
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         n_mismatch++;
         final_report;
      end
   end
   initial begin
      repeat (2) @(posedge clk);
      #1;
      rstn = 1'b1;
      chk("status", 22'h0, cfg & 22'h18);
      t_fields;
      t_dbi;
      t_parity;
      t_mps;
      final_report;
   end
endmodule // dmc_mode_config_tb
`default_nettype wire
